// [dv/testbench.sv]
// self-checking bench for the reset retention matrix
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// signals and expected register image
	// ****************************************
	function automatic logic [rrm_pkg::NREG-1:0][rrm_pkg::DW-1:0] make_iv();
		for (int i = 0; i < rrm_pkg::NREG; i++) begin
			make_iv[i] = 8'ha0 + 8'(i);
		end
	endfunction
	localparam logic [rrm_pkg::NREG-1:0][rrm_pkg::DW-1:0] IV = make_iv();

	logic                mclk = 1'b0;
	logic                rst_n = 1'b0;
	logic                hard_sw_n = 1'b1;
	logic                reset_sw_n = 1'b1;
	rrm_pkg::rrm_wr_s    wr = '0;
	rrm_pkg::rrm_idx_t   rd_idx = '0;
	rrm_pkg::rrm_data_t  rd_data;
	rrm_pkg::rrm_cond_s  sys_reset;
	logic                switch_reset_en;
	logic                system_power;
	rrm_pkg::rrm_data_t  touch_control;
	rrm_pkg::rrm_data_t  key_control;
	rrm_pkg::rrm_data_t  power_ctrl_second;
	rrm_pkg::rrm_data_t  lamp_level;
	rrm_pkg::rrm_data_t  front_light_level;
	rrm_pkg::rrm_data_t  exp_r [rrm_pkg::NREG];
	rrm_pkg::rrm_data_t  cnt [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
	rrm_pkg::rrm_data_t  base [4];
	int                  bad_count = 0;
	int                  checks = 0;
	int                  cyc = 0;

	always #20 mclk = ~mclk;

	rrm_top #(.INIT_VAL(IV)) u_dut (
		.mclk              (mclk),
		.rst_n             (rst_n),
		.hard_sw_n         (hard_sw_n),
		.reset_sw_n        (reset_sw_n),
		.wr                (wr),
		.rd_idx            (rd_idx),
		.rd_data           (rd_data),
		.sys_reset         (sys_reset),
		.switch_reset_en   (switch_reset_en),
		.system_power      (system_power),
		.touch_control     (touch_control),
		.key_control       (key_control),
		.power_ctrl_second (power_ctrl_second),
		.lamp_level        (lamp_level),
		.front_light_level (front_light_level)
	);

	// counts condition pulses; also cuts a hang short
	always @(posedge mclk) begin
		if (sys_reset.a === 1'b1) cnt[0] <= cnt[0] + 8'h01;
		if (sys_reset.b === 1'b1) cnt[1] <= cnt[1] + 8'h01;
		if (sys_reset.c === 1'b1) cnt[2] <= cnt[2] + 8'h01;
		if (sys_reset.d === 1'b1) cnt[3] <= cnt[3] + 8'h01;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			finish_test();
		end
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic finish_test();
		if (bad_count == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input rrm_pkg::rrm_data_t seen, input rrm_pkg::rrm_data_t expv);
		checks++;
		if (seen !== expv) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
		end
	endtask

	task automatic tick();
		@(posedge mclk);
		#1;
	endtask

	// applies a resolved condition to the expected image: 0=a 1=b 2=c 3=d
	task automatic model(input int kind);
		logic cal;
		logic zer;
		for (int i = 0; i < rrm_pkg::NREG; i++) begin
			cal = (i >= rrm_pkg::CAL_DOT_LO && i <= rrm_pkg::DOTCALC_HI);
			zer = (i == rrm_pkg::IDX_PWR_FIRST || i == rrm_pkg::IDX_LAMP
				|| i == rrm_pkg::IDX_FRONT_LIGHT);
			if (kind == 0) exp_r[i] = IV[i];
			else if (kind == 1 && !cal) exp_r[i] = IV[i];
			else if (kind == 3 && !cal) exp_r[i] = zer ? rrm_pkg::FORCED_OFF_VAL : IV[i];
		end
	endtask

	// leaves the strobe up; wr_end drops it, so no signal is set twice in a step
	task automatic wr_reg(input int idx, input rrm_pkg::rrm_data_t data);
		wr = '{en: 1'b1, idx: rrm_pkg::rrm_idx_t'(idx), data: data};
		tick();
		if (idx < rrm_pkg::NREG) exp_r[idx] = data;
		if (idx == rrm_pkg::IDX_RESET_CTRL && data[rrm_pkg::SOFT_RESET_BIT]) model(1);
		if (idx == rrm_pkg::IDX_PWR_FIRST && !data[rrm_pkg::SYSTEM_POWER_BIT]) model(3);
	endtask

	task automatic wr_end();
		wr.en = 1'b0;
		repeat (2) tick();
	endtask

	task automatic check_all();
		for (int i = 0; i < rrm_pkg::NREG; i++) begin
			rd_idx = rrm_pkg::rrm_idx_t'(i);
			tick();
			tick();
			check(rd_data, exp_r[i]);
		end
		check(touch_control, exp_r[0]);
		check(key_control, exp_r[32]);
		check(power_ctrl_second, exp_r[37]);
		check(lamp_level, exp_r[38]);
		check(front_light_level, exp_r[39]);
		check({7'h00, switch_reset_en}, {7'h00, exp_r[40][1]});
		check({7'h00, system_power}, {7'h00, exp_r[36][0]});
	endtask

	// writes 8'h30 plus the index everywhere, bit 0 forced on at IDX_PWR_FIRST, without firing a condition
	task automatic fill();
		for (int i = 0; i < rrm_pkg::NREG; i++) begin
			wr_reg(i, (8'h30 + 8'(i)) | ((i == rrm_pkg::IDX_PWR_FIRST) ? 8'h01 : 8'h00));
		end
		wr_end();
	endtask

	task automatic snap();
		base = cnt;
	endtask

	task automatic pulses(input logic [3:0] e);
		check(cnt[0] - base[0], {7'h00, e[3]});
		check(cnt[1] - base[1], {7'h00, e[2]});
		check(cnt[2] - base[2], {7'h00, e[1]});
		check(cnt[3] - base[3], {7'h00, e[0]});
	endtask

	task automatic press(input logic hard);
		if (hard) hard_sw_n = 1'b0;
		else reset_sw_n = 1'b0;
		repeat (4) tick();
		hard_sw_n = 1'b1;
		reset_sw_n = 1'b1;
		repeat (4) tick();
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		repeat (8) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		model(0);
		repeat (4) tick();
		check(cnt[0], 8'h01);
		check_all();
	endtask

	task automatic t_fill_unmapped();
		fill();
		wr_reg(45, 8'h77);
		wr_end();
		rd_idx = 6'h2d;
		tick();
		tick();
		check(rd_data, 8'h00);
		check_all();
	endtask

	task automatic t_switch(input logic enable);
		fill();
		wr_reg(rrm_pkg::IDX_RESET_CTRL, enable ? 8'h02 : 8'h00);
		wr_end();
		snap();
		press(1'b0);
		if (enable) model(1);
		pulses(enable ? 4'b0100 : 4'b0010);
		check_all();
	endtask

	task automatic t_write_cond(input int idx, input rrm_pkg::rrm_data_t data, input logic [3:0] e);
		fill();
		snap();
		wr_reg(idx, data);
		wr_end();
		pulses(e);
		check_all();
	endtask

	task automatic t_hard();
		fill();
		snap();
		press(1'b1);
		model(0);
		pulses(4'b1000);
		check_all();
	endtask

	// power drops in mid-run and returns: the whole store starts over
	task automatic t_power_cycle();
		fill();
		snap();
		rst_n = 1'b0;
		tick();
		check(lamp_level, IV[rrm_pkg::IDX_LAMP]);
		check(touch_control, IV[rrm_pkg::TOUCH_LO]);
		check({4'h0, sys_reset}, 8'h00);
		rst_n = 1'b1;
		model(0);
		repeat (4) tick();
		pulses(4'b1000);
		check_all();
	endtask

	// enabled switch press lands on the same edge as a power-off write
	task automatic t_coincide();
		fill();
		wr_reg(rrm_pkg::IDX_RESET_CTRL, 8'h02);
		wr_end();
		snap();
		reset_sw_n = 1'b0;
		tick();
		tick();
		wr = '{en: 1'b1, idx: rrm_pkg::rrm_idx_t'(rrm_pkg::IDX_PWR_FIRST), data: 8'h00};
		tick();
		wr.en = 1'b0;
		tick();
		reset_sw_n = 1'b1;
		repeat (4) tick();
		model(1);
		pulses(4'b0100);
		check_all();
	endtask

	initial begin
		t_reset();
		t_fill_unmapped();
		t_switch(1'b0);
		t_switch(1'b1);
		t_write_cond(rrm_pkg::IDX_RESET_CTRL, 8'h01, 4'b0100);
		t_write_cond(rrm_pkg::IDX_PWR_FIRST, 8'h00, 4'b0001);
		t_hard();
		t_power_cycle();
		t_coincide();
		finish_test();
	end
endmodule

// [rtl/rrm_cond_decode.sv]
// reset condition decoder: switch synchronisers, press detection and priority
module rrm_cond_decode (
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic              hard_sw_n,
	input  wire logic              reset_sw_n,
	input  wire rrm_pkg::rrm_wr_s  wr,
	input  wire logic              sw_reset_en,
	output rrm_pkg::rrm_cond_s     cond
);

	// ****************************************
	// pin synchronisers, bit 0 hard switch, bit 1 reset switch
	// ****************************************
	logic [1:0] sync1_r;
	logic [1:0] sync2_r;
	logic [1:0] sync3_r;
	logic       por_pend_r;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= 2'h3;
			sync2_r <= 2'h3;
			sync3_r <= 2'h3;
		end else begin
			sync1_r <= {reset_sw_n, hard_sw_n};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	// one cycle of condition a right after power-on release
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			por_pend_r <= 1'b1;
		end else begin
			por_pend_r <= 1'b0;
		end
	end

	// ****************************************
	// raw conditions and priority
	// ****************************************
	logic [1:0] press;
	logic       a_raw;
	logic       b_raw;
	logic       c_raw;
	logic       d_raw;

	assign press = sync3_r & ~sync2_r;
	assign a_raw = por_pend_r | press[0];
	assign b_raw = (wr.en && wr.idx == rrm_pkg::IW'(rrm_pkg::IDX_RESET_CTRL)
	                && wr.data[rrm_pkg::SOFT_RESET_BIT])
	               || (press[1] && sw_reset_en);
	assign c_raw = press[1] && !sw_reset_en;
	assign d_raw = wr.en && wr.idx == rrm_pkg::IW'(rrm_pkg::IDX_PWR_FIRST)
	               && !wr.data[rrm_pkg::SYSTEM_POWER_BIT];

	// strongest condition alone survives: a, then b, then d, then c
	assign cond.a = a_raw;
	assign cond.b = b_raw && !a_raw;
	assign cond.d = d_raw && !a_raw && !b_raw;
	assign cond.c = c_raw && !a_raw && !b_raw && !d_raw;

	// ****************************************
	// checks
	// ****************************************
	a_switch_b_cond: assert property (@(posedge mclk) disable iff (!rst_n)
		press[1] && sw_reset_en |-> cond.b || cond.a)
		else $error("reset switch with enable set did not give condition b");
	a_switch_c_cond: assert property (@(posedge mclk) disable iff (!rst_n)
		$fell(sync2_r[1]) && !sw_reset_en && !a_raw && !b_raw && !d_raw |-> cond.c)
		else $error("reset switch with enable clear did not give condition c");
	a_power_off_d: assert property (@(posedge mclk) disable iff (!rst_n)
		d_raw && !cond.a && !cond.b |-> cond.d)
		else $error("system power bit cleared without condition d");
	a_cond_onehot: assert property (@(posedge mclk) disable iff (!rst_n)
		$onehot0({cond.a, cond.b, cond.c, cond.d}) && (!(b_raw && !a_raw) || cond.b))
		else $error("reset conditions not resolved to the strongest one");

endmodule

// [rtl/rrm_pad_unused.sv]
// holds no logic

// [rtl/rrm_pkg.sv]
// shared constants, types and the register class table of the reset retention matrix
package rrm_pkg;

	// ****************************************
	// widths and register map
	// ****************************************
	localparam int DW   = 8;
	localparam int IW   = 6;
	localparam int NREG = 41;

	typedef logic [IW-1:0] rrm_idx_t;
	typedef logic [DW-1:0] rrm_data_t;

	localparam rrm_idx_t NREG_I = IW'(NREG);

	// touch control, status, sampling control, x/y conversion and x/y screen dot
	localparam int TOUCH_LO    = 0;
	localparam int TOUCH_HI    = 6;
	// calibration dots for points a, b, c on both axes, then x and y dot span
	localparam int CAL_DOT_LO  = 7;
	localparam int CAL_DOT_HI  = 14;
	// calibration conversion values for points a, b, c on both axes
	localparam int CAL_CONV_LO = 15;
	localparam int CAL_CONV_HI = 20;
	// x base plus four companions, then y base plus four companions
	localparam int DOTCALC_LO  = 21;
	localparam int DOTCALC_HI  = 30;
	localparam int IDX_SHARED_STATUS = 31;
	// key control, repeat interval, key status, key pattern
	localparam int KEY_LO      = 32;
	localparam int KEY_HI      = 35;
	localparam int IDX_PWR_FIRST   = 36;
	localparam int IDX_PWR_SECOND  = 37;
	localparam int IDX_LAMP        = 38;
	localparam int IDX_FRONT_LIGHT = 39;
	localparam int IDX_RESET_CTRL  = 40;

	// ****************************************
	// control fields and forced values
	// ****************************************
	localparam int SOFT_RESET_BIT          = 0;
	localparam int SWITCH_RESET_ENABLE_BIT = 1;
	localparam int SYSTEM_POWER_BIT        = 0;
	localparam rrm_data_t FORCED_OFF_VAL   = 8'h00;
	localparam rrm_data_t INIT_DEFAULT     = 8'h00;

	// ****************************************
	// types
	// ****************************************
	// how a register reacts: init on a/b/d, init on a only, init on a/b with zero on d
	typedef enum logic [1:0] {
		RRM_CLS_ABD,
		RRM_CLS_A,
		RRM_CLS_ABZ
	} rrm_cls_e;

	typedef struct packed {
		logic a;
		logic b;
		logic c;
		logic d;
	} rrm_cond_s;

	typedef struct packed {
		logic      en;
		rrm_idx_t  idx;
		rrm_data_t data;
	} rrm_wr_s;

	function automatic rrm_cls_e cls_of(input int idx);
		if (idx >= CAL_DOT_LO && idx <= DOTCALC_HI) begin
			return RRM_CLS_A;
		end else if (idx == IDX_PWR_FIRST || idx == IDX_LAMP || idx == IDX_FRONT_LIGHT) begin
			return RRM_CLS_ABZ;
		end else begin
			return RRM_CLS_ABD;
		end
	endfunction

endpackage

// [rtl/rrm_top.sv]
// reset retention matrix: power supply controller registers and their reset behaviour
module rrm_top #(
	parameter logic [rrm_pkg::NREG-1:0][rrm_pkg::DW-1:0] INIT_VAL =
		{rrm_pkg::NREG{rrm_pkg::INIT_DEFAULT}}
) (
	input  wire logic                mclk,
	input  wire logic                rst_n,
	input  wire logic                hard_sw_n,
	input  wire logic                reset_sw_n,
	input  wire rrm_pkg::rrm_wr_s    wr,
	input  wire rrm_pkg::rrm_idx_t   rd_idx,
	output rrm_pkg::rrm_data_t       rd_data,
	output rrm_pkg::rrm_cond_s       sys_reset,
	output logic                     switch_reset_en,
	output logic                     system_power,
	output rrm_pkg::rrm_data_t       touch_control,
	output rrm_pkg::rrm_data_t       key_control,
	output rrm_pkg::rrm_data_t       power_ctrl_second,
	output rrm_pkg::rrm_data_t       lamp_level,
	output rrm_pkg::rrm_data_t       front_light_level
);

	// ****************************************
	// register store and condition decode
	// ****************************************
	logic [rrm_pkg::NREG-1:0][rrm_pkg::DW-1:0] reg_r;
	rrm_pkg::rrm_cond_s                         cond;
	rrm_pkg::rrm_cond_s                         sys_reset_r;
	rrm_pkg::rrm_data_t                         rd_data_r;

	rrm_cond_decode u_cond (
		.mclk        (mclk),
		.rst_n       (rst_n),
		.hard_sw_n   (hard_sw_n),
		.reset_sw_n  (reset_sw_n),
		.wr          (wr),
		.sw_reset_en (reg_r[rrm_pkg::IDX_RESET_CTRL][rrm_pkg::SWITCH_RESET_ENABLE_BIT]),
		.cond        (cond)
	);

	// ****************************************
	// per register update: reset class first, software write last
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < rrm_pkg::NREG; g++) begin : g_reg
			localparam rrm_pkg::rrm_cls_e CLS = rrm_pkg::cls_of(g);
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					reg_r[g] <= INIT_VAL[g];
				end else if (cond.a) begin
					reg_r[g] <= INIT_VAL[g];
				end else if (cond.b && CLS != rrm_pkg::RRM_CLS_A) begin
					reg_r[g] <= INIT_VAL[g];
				end else if (cond.d && CLS == rrm_pkg::RRM_CLS_ABD) begin
					reg_r[g] <= INIT_VAL[g];
				end else if (cond.d && CLS == rrm_pkg::RRM_CLS_ABZ) begin
					reg_r[g] <= rrm_pkg::FORCED_OFF_VAL;
				end else if (wr.en && wr.idx == rrm_pkg::IW'(g)) begin
					reg_r[g] <= wr.data;
				end
			end

			// condition c never touches a register, only a write may
			a_reg_hold_c: assert property (@(posedge mclk) disable iff (!rst_n)
				cond.c && !(wr.en && wr.idx == rrm_pkg::IW'(g)) |=> $stable(reg_r[g]))
				else $error("register changed under condition c");
			if (CLS == rrm_pkg::RRM_CLS_A) begin : g_keep
				a_reg_keep_bd: assert property (@(posedge mclk) disable iff (!rst_n)
					(cond.b || cond.d) && !(wr.en && wr.idx == rrm_pkg::IW'(g))
					|=> $stable(reg_r[g]))
					else $error("calibration register lost outside condition a");
			end else begin : g_init
				a_reg_init_b: assert property (@(posedge mclk) disable iff (!rst_n)
					cond.b |=> reg_r[g] == INIT_VAL[g])
					else $error("register not initialised under condition b");
			end
		end
	endgenerate

	// ****************************************
	// read port and condition outputs
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_r <= rrm_pkg::INIT_DEFAULT;
		end else if (rd_idx < rrm_pkg::NREG_I) begin
			rd_data_r <= reg_r[rd_idx];
		end else begin
			rd_data_r <= rrm_pkg::INIT_DEFAULT;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sys_reset_r <= '0;
		end else begin
			sys_reset_r <= cond;
		end
	end

	assign rd_data           = rd_data_r;
	assign sys_reset         = sys_reset_r;
	assign switch_reset_en   =
		reg_r[rrm_pkg::IDX_RESET_CTRL][rrm_pkg::SWITCH_RESET_ENABLE_BIT];
	assign system_power      = reg_r[rrm_pkg::IDX_PWR_FIRST][rrm_pkg::SYSTEM_POWER_BIT];
	assign touch_control     = reg_r[rrm_pkg::TOUCH_LO];
	assign key_control       = reg_r[rrm_pkg::KEY_LO];
	assign power_ctrl_second = reg_r[rrm_pkg::IDX_PWR_SECOND];
	assign lamp_level        = reg_r[rrm_pkg::IDX_LAMP];
	assign front_light_level = reg_r[rrm_pkg::IDX_FRONT_LIGHT];

	// ****************************************
	// checks
	// ****************************************
	logic hit_touch;
	logic hit_cal_dot;
	logic hit_cal_conv;
	logic hit_dotcalc;
	logic hit_key;
	logic init_abd;

	assign hit_touch    = wr.en && wr.idx <= rrm_pkg::IW'(rrm_pkg::TOUCH_HI);
	assign hit_cal_dot  = wr.en && wr.idx >= rrm_pkg::IW'(rrm_pkg::CAL_DOT_LO)
	                      && wr.idx <= rrm_pkg::IW'(rrm_pkg::CAL_DOT_HI);
	assign hit_cal_conv = wr.en && wr.idx >= rrm_pkg::IW'(rrm_pkg::CAL_CONV_LO)
	                      && wr.idx <= rrm_pkg::IW'(rrm_pkg::CAL_CONV_HI);
	assign hit_dotcalc  = wr.en && wr.idx >= rrm_pkg::IW'(rrm_pkg::DOTCALC_LO)
	                      && wr.idx <= rrm_pkg::IW'(rrm_pkg::DOTCALC_HI);
	assign hit_key      = wr.en && wr.idx >= rrm_pkg::IW'(rrm_pkg::KEY_LO)
	                      && wr.idx <= rrm_pkg::IW'(rrm_pkg::KEY_HI);
	assign init_abd     = cond.a || cond.b || cond.d;

	a_full_init: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.a |=> reg_r == INIT_VAL && sys_reset.a)
		else $error("condition a left a register off its initial value");

	a_touch_ctrl_init: assert property (@(posedge mclk) disable iff (!rst_n)
		init_abd |=> reg_r[2:0] == INIT_VAL[2:0])
		else $error("touch control group not initialised");
	a_touch_ctrl_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.c && !hit_touch |=> reg_r[2:0] == $past(reg_r[2:0]))
		else $error("touch control group changed under condition c");

	a_touch_res_init: assert property (@(posedge mclk) disable iff (!rst_n)
		init_abd |=> reg_r[rrm_pkg::TOUCH_HI:3] == INIT_VAL[rrm_pkg::TOUCH_HI:3])
		else $error("touch results not initialised");
	a_touch_res_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.c && !hit_touch
		|=> reg_r[rrm_pkg::TOUCH_HI:3] == $past(reg_r[rrm_pkg::TOUCH_HI:3]))
		else $error("touch results changed under condition c");

	a_cal_dot_keep: assert property (@(posedge mclk) disable iff (!rst_n)
		(cond.b || cond.c || cond.d) && !hit_cal_dot
		|=> reg_r[rrm_pkg::CAL_DOT_HI:rrm_pkg::CAL_DOT_LO]
		    == $past(reg_r[rrm_pkg::CAL_DOT_HI:rrm_pkg::CAL_DOT_LO]))
		else $error("calibration dots lost outside condition a");

	a_cal_conv_keep: assert property (@(posedge mclk) disable iff (!rst_n)
		(cond.b || cond.c || cond.d) && !hit_cal_conv
		|=> reg_r[rrm_pkg::CAL_CONV_HI:rrm_pkg::CAL_CONV_LO]
		    == $past(reg_r[rrm_pkg::CAL_CONV_HI:rrm_pkg::CAL_CONV_LO]))
		else $error("calibration conversion values lost outside condition a");

	a_dotcalc_keep: assert property (@(posedge mclk) disable iff (!rst_n)
		(cond.b || cond.c || cond.d) && !hit_dotcalc
		|=> reg_r[rrm_pkg::DOTCALC_HI:rrm_pkg::DOTCALC_LO]
		    == $past(reg_r[rrm_pkg::DOTCALC_HI:rrm_pkg::DOTCALC_LO]))
		else $error("dot calculation values lost outside condition a");

	a_shared_status: assert property (@(posedge mclk) disable iff (!rst_n)
		init_abd |=> reg_r[rrm_pkg::IDX_SHARED_STATUS] == INIT_VAL[rrm_pkg::IDX_SHARED_STATUS])
		else $error("shared status not initialised");
	a_shared_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.c && !wr.en |=> $stable(reg_r[rrm_pkg::IDX_SHARED_STATUS]))
		else $error("shared status changed under condition c");

	a_key_init_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.c && !hit_key
		|=> reg_r[rrm_pkg::KEY_HI:rrm_pkg::KEY_LO] == $past(reg_r[rrm_pkg::KEY_HI:rrm_pkg::KEY_LO]))
		else $error("key registers changed under condition c");
	a_key_init: assert property (@(posedge mclk) disable iff (!rst_n)
		init_abd |=> reg_r[rrm_pkg::KEY_HI:rrm_pkg::KEY_LO]
		             == INIT_VAL[rrm_pkg::KEY_HI:rrm_pkg::KEY_LO])
		else $error("key registers not initialised");

	a_pwr_first_off: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.d |=> reg_r[rrm_pkg::IDX_PWR_FIRST] == rrm_pkg::FORCED_OFF_VAL && !system_power)
		else $error("first power control not forced off under condition d");
	a_pwr_first_b: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.b |=> reg_r[rrm_pkg::IDX_PWR_FIRST] == INIT_VAL[rrm_pkg::IDX_PWR_FIRST])
		else $error("first power control not initialised under condition b");

	a_pwr_second: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.d |=> power_ctrl_second == INIT_VAL[rrm_pkg::IDX_PWR_SECOND])
		else $error("second power control not initialised under condition d");

	a_lamp_off: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.d ##1 (!wr.en && !cond.a && !cond.b)[*2] |=> lamp_level == rrm_pkg::FORCED_OFF_VAL)
		else $error("lamp not held cleared after condition d");

	a_front_light: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.d |=> front_light_level == rrm_pkg::FORCED_OFF_VAL)
		else $error("front light not cleared under condition d");
	a_front_light_c: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.c && !wr.en |=> $stable(front_light_level) && $stable(lamp_level))
		else $error("front light or lamp changed under condition c");

	a_reset_ctrl: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.c && !wr.en |=> $stable(switch_reset_en) && sys_reset.c)
		else $error("switch reset selection lost across a switch reset");
	a_reset_ctrl_b: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.b |=> reg_r[rrm_pkg::IDX_RESET_CTRL] == INIT_VAL[rrm_pkg::IDX_RESET_CTRL])
		else $error("reset control not initialised under condition b");

	a_prio_out: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.b && cond.d == 1'b0 |=> sys_reset.b && !sys_reset.d && !sys_reset.c)
		else $error("condition output not the strongest one");

	// ****************************************
	// checks on the visible outputs and the register store
	// ****************************************
	a_out_b_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.b |=> sys_reset.b && !sys_reset.a)
		else $error("condition b not shown on the output");
	a_out_c_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.c |=> sys_reset.c && !sys_reset.b && !sys_reset.d)
		else $error("condition c not shown on the output");
	a_out_d_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.d |=> sys_reset.d && !system_power)
		else $error("condition d not shown on the output");
	a_out_one_cycle: assert property (@(posedge mclk) disable iff (!rst_n)
		!cond.a && !cond.b && !cond.c && !cond.d |=> sys_reset == '0)
		else $error("condition output outlived its cycle");
	a_store_c_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.c && !wr.en |=> $stable(reg_r))
		else $error("condition c changed the register store");

	a_cal_dot_a: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.a |=> reg_r[rrm_pkg::CAL_DOT_HI:rrm_pkg::CAL_DOT_LO]
		           == INIT_VAL[rrm_pkg::CAL_DOT_HI:rrm_pkg::CAL_DOT_LO])
		else $error("calibration dots not initialised under condition a");
	a_cal_conv_a: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.a |=> reg_r[rrm_pkg::CAL_CONV_HI:rrm_pkg::CAL_CONV_LO]
		           == INIT_VAL[rrm_pkg::CAL_CONV_HI:rrm_pkg::CAL_CONV_LO])
		else $error("calibration conversion values not initialised under condition a");
	a_dotcalc_a: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.a |=> reg_r[rrm_pkg::DOTCALC_HI:rrm_pkg::DOTCALC_LO]
		           == INIT_VAL[rrm_pkg::DOTCALC_HI:rrm_pkg::DOTCALC_LO])
		else $error("dot calculation values not initialised under condition a");

	a_touch_out_b: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.b |=> touch_control == INIT_VAL[rrm_pkg::TOUCH_LO])
		else $error("touch control not initialised under condition b");
	a_touch_out_d: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.d |=> touch_control == INIT_VAL[rrm_pkg::TOUCH_LO])
		else $error("touch control not initialised under condition d");
	a_key_out_b: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.b |=> key_control == INIT_VAL[rrm_pkg::KEY_LO])
		else $error("key control not initialised under condition b");
	a_key_out_d: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.d |=> key_control == INIT_VAL[rrm_pkg::KEY_LO])
		else $error("key control not initialised under condition d");

	a_pwr_first_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.c && !wr.en
		|=> $stable(system_power) && $stable(reg_r[rrm_pkg::IDX_PWR_FIRST]))
		else $error("first power control changed under condition c");
	a_pwr_second_b: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.b |=> power_ctrl_second == INIT_VAL[rrm_pkg::IDX_PWR_SECOND])
		else $error("second power control not initialised under condition b");
	a_pwr_second_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.c && !wr.en |=> $stable(power_ctrl_second))
		else $error("second power control changed under condition c");

	a_lamp_b: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.b |=> lamp_level == INIT_VAL[rrm_pkg::IDX_LAMP])
		else $error("lamp not initialised under condition b");
	a_lamp_d: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.d |=> lamp_level == rrm_pkg::FORCED_OFF_VAL)
		else $error("lamp not cleared under condition d");
	a_front_light_b: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.b |=> front_light_level == INIT_VAL[rrm_pkg::IDX_FRONT_LIGHT])
		else $error("front light not initialised under condition b");

	a_reset_ctrl_d: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.d |=> reg_r[rrm_pkg::IDX_RESET_CTRL] == INIT_VAL[rrm_pkg::IDX_RESET_CTRL])
		else $error("reset control not initialised under condition d");
	a_reset_ctrl_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		cond.c && !wr.en |=> $stable(reg_r[rrm_pkg::IDX_RESET_CTRL]))
		else $error("reset control changed under condition c");

endmodule
